// file: logic/hpsc_pkg.sv
// Constants for the slot hot-plug control and status block
package hpsc_pkg;
    // Register map: one word, control low half, status high half
    localparam logic [7:0]  SLOT_WORD_OFS   = 8'hF8;
    localparam int          ADDR_W          = 8;
    // Control field positions
    localparam int          CTL_ABP_EN      = 0;
    localparam int          CTL_PFD_EN      = 1;
    localparam int          CTL_PDC_EN      = 3;
    localparam int          CTL_CC_EN       = 4;
    localparam int          CTL_HP_EN       = 5;
    localparam int          CTL_ATTN_LO     = 6;
    localparam int          CTL_PWRI_LO     = 8;
    localparam int          CTL_PWR_OFF     = 10;
    localparam int          CTL_DLL_EN      = 12;
    // Status field positions (within the word)
    localparam int          STS_ABP         = 16;
    localparam int          STS_PFD         = 17;
    localparam int          STS_LATCH_CHG   = 18;
    localparam int          STS_PDC         = 19;
    localparam int          STS_CC          = 20;
    localparam int          STS_LATCH_ST    = 21;
    localparam int          STS_PRES_ST     = 22;
    localparam int          STS_DLL_CHG     = 24;
    // Writable control bit mask and reset values
    localparam logic [15:0] CTL_WMASK       = 16'h17FB;
    localparam logic [15:0] CTL_RESET       = 16'h03C0;
    localparam logic [1:0]  IND_OFF         = 2'h3;
    // Cycles from a control change to command completion
    localparam int          CMD_CYCLES      = 2;
endpackage

// file: logic/hpsc_slot.sv
// Slot hot-plug control and status register with event latching
//
// Summary of operation
// - Control low half, status high half, 0xF8
// - Bit 0 enables attention button event
// - Bit 1 enables power fault event
// - Bit 3 enables presence change event
// - Bit 4 enables command completed interrupt
// - Bit 5 is master interrupt enable
// - Attention indicator field, message on write
// - Power indicator field, message on write
// - Bit 10 one turns slot power off
// - Bit 12 enables link state notification
// - Bit 16 latches button press, W1C
// - Bit 17 latches power fault, W1C
// - Bit 18 shows latch sensor change, read-only
// - Bit 19 latches presence change, W1C
// - Bit 20 latches command completion, W1C
// - Bit 21 reflects latch sensor open
// - Bit 22 presence; no slot reads one
// - Bit 24 latches link active change, W1C
`timescale 1ns/1ps
module hpsc_slot
    import hpsc_pkg::*;
(
    // Clock and reset
    input  wire logic                  i_clk,
    input  wire logic                  i_srst,
    // Register port
    input  wire logic [hpsc_pkg::ADDR_W-1:0] i_addr,
    input  wire logic [31:0]           i_wdata,
    input  wire logic                  i_wr,
    input  wire logic                  i_rd,
    output logic      [31:0]           o_rdata,
    // Slot sensors and port state
    input  wire logic                  i_slot_impl,
    input  wire logic                  i_dll_supported,
    input  wire logic                  i_button_press,
    input  wire logic                  i_power_fault,
    input  wire logic                  i_latch_open,
    input  wire logic                  i_card_present,
    input  wire logic                  i_link_active,
    // Slot controls, indicator messages and interrupt request
    output logic      [1:0]            o_attn_ind,
    output logic      [1:0]            o_pwr_ind,
    output logic                       o_attn_msg,
    output logic                       o_pwr_msg,
    output logic                       o_slot_power_off,
    output logic                       o_hp_irq
);
    import hpsc_pkg::*;

    ////////////////////////////////////////////////////////////////////
    logic [15:0] ctl;
    logic        abp, pfd, latch_chg, pdc, cc, dll_chg;
    logic        latch_q, pres_q, link_q, pres_prev_valid;
    logic [1:0]  cmd_cnt;

    // Decode of the single register word
    wire         hit      = (i_addr == SLOT_WORD_OFS);
    wire         wr_hit   = i_wr & hit;
    wire [15:0]  next_ctl = (ctl & ~CTL_WMASK) | (i_wdata[15:0] & CTL_WMASK);
    wire         ctl_cmd  = wr_hit & ((next_ctl[10:6] != ctl[10:6]));
    wire         pres_now = i_slot_impl ? i_card_present : 1'b1;
    wire         link_now = i_dll_supported & i_link_active;
    wire         cc_done  = (cmd_cnt == 2'(1));

    // Assembled read value; reserved bits read zero
    wire [31:0]  rd_word  = {7'h00, dll_chg, 1'b0, pres_q, latch_q, cc, pdc,
                             latch_chg, pfd, abp, ctl};

    // Interrupt request from enabled flags under master enable
    wire         irq_any  = ctl[CTL_HP_EN] &
                            ((abp & ctl[CTL_ABP_EN]) |
                             (pfd & ctl[CTL_PFD_EN]) |
                             (pdc & ctl[CTL_PDC_EN]) |
                             (cc  & ctl[CTL_CC_EN])  |
                             (dll_chg & ctl[CTL_DLL_EN] & i_dll_supported));

    // W1C helper: set wins over clear
    function automatic logic flag_next(input logic cur, input logic set, input logic clr);
        flag_next = set | (cur & ~clr);
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Control register
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            ctl <= CTL_RESET;
        end else if (wr_hit) begin
            ctl <= next_ctl;
        end
    end

    // Sensor sampling for change detection
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            latch_q         <= 1'b0;
            pres_q          <= 1'b1;
            link_q          <= 1'b0;
            pres_prev_valid <= 1'b0;
        end else begin
            latch_q         <= i_latch_open;
            pres_q          <= pres_now;
            link_q          <= link_now;
            pres_prev_valid <= 1'b1;
        end
    end

    // Command completion timer
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            cmd_cnt <= 2'h0;
        end else if (ctl_cmd) begin
            cmd_cnt <= 2'(CMD_CYCLES);
        end else if (cmd_cnt != 2'h0) begin
            cmd_cnt <= cmd_cnt - 2'h1;
        end
    end

    // Event flags
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            abp       <= 1'b0;
            pfd       <= 1'b0;
            latch_chg <= 1'b0;
            pdc       <= 1'b0;
            cc        <= 1'b0;
            dll_chg   <= 1'b0;
        end else begin
            abp       <= flag_next(abp, i_button_press, wr_hit & i_wdata[STS_ABP]);
            pfd       <= flag_next(pfd, i_power_fault, wr_hit & i_wdata[STS_PFD]);
            latch_chg <= latch_chg | (latch_q != i_latch_open);
            pdc       <= flag_next(pdc, pres_prev_valid & (pres_q != pres_now),
                                   wr_hit & i_wdata[STS_PDC]);
            cc        <= flag_next(cc, cc_done, wr_hit & i_wdata[STS_CC]);
            dll_chg   <= flag_next(dll_chg, link_q != link_now,
                                   wr_hit & i_wdata[STS_DLL_CHG]);
        end
    end

    // Outputs, all registered
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_rdata          <= 32'h0000_0000;
            o_attn_ind       <= IND_OFF;
            o_pwr_ind        <= IND_OFF;
            o_attn_msg       <= 1'b0;
            o_pwr_msg        <= 1'b0;
            o_slot_power_off <= 1'b0;
            o_hp_irq         <= 1'b0;
        end else begin
            o_rdata          <= (i_rd & hit) ? rd_word : 32'h0000_0000;
            o_attn_ind       <= ctl[CTL_ATTN_LO +: 2];
            o_pwr_ind        <= ctl[CTL_PWRI_LO +: 2];
            o_attn_msg       <= wr_hit;
            o_pwr_msg        <= wr_hit;
            o_slot_power_off <= ctl[CTL_PWR_OFF];
            o_hp_irq         <= irq_any;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks
    a_master_gate_off: assert property (@(posedge i_clk) disable iff (i_srst)
        !ctl[CTL_HP_EN] |=> !o_hp_irq)
        else $error("interrupt raised without master enable");
    a_button_latch: assert property (@(posedge i_clk) disable iff (i_srst)
        i_button_press |=> abp)
        else $error("button press not latched");
    a_fault_latch: assert property (@(posedge i_clk) disable iff (i_srst)
        i_power_fault |=> pfd)
        else $error("power fault not latched");
    a_w1c_zero_keep: assert property (@(posedge i_clk) disable iff (i_srst)
        (wr_hit && !i_wdata[STS_ABP] && abp) |=> abp)
        else $error("flag lost on zero write");
    a_cmd_complete: assert property (@(posedge i_clk) disable iff (i_srst)
        ctl_cmd |-> ##[1:4] cc)
        else $error("command completed not set");
    a_ind_msg: assert property (@(posedge i_clk) disable iff (i_srst)
        wr_hit |=> (o_attn_msg && o_pwr_msg)
            ##1 (o_attn_ind == $past(i_wdata[CTL_ATTN_LO +: 2], 2)))
        else $error("indicator message missing");
    a_pwr_follow: assert property (@(posedge i_clk) disable iff (i_srst)
        wr_hit |-> ##2 o_slot_power_off == $past(i_wdata[CTL_PWR_OFF], 2))
        else $error("power control not applied");
    a_button_irq: assert property (@(posedge i_clk) disable iff (i_srst)
        (abp && ctl[CTL_ABP_EN] && ctl[CTL_HP_EN]) |=> o_hp_irq)
        else $error("enabled button event gave no interrupt");
    a_read_data: assert property (@(posedge i_clk) disable iff (i_srst)
        (i_rd && hit) |=> o_rdata[15:0] == $past(ctl))
        else $error("control half misread");

    // Write-one clears, when no new event arrives
    a_abp_clear: assert property (@(posedge i_clk) disable iff (i_srst)
        (wr_hit && i_wdata[STS_ABP] && !i_button_press) |=> !abp)
        else $error("button flag not cleared");

    a_pfd_clear: assert property (@(posedge i_clk) disable iff (i_srst)
        (wr_hit && i_wdata[STS_PFD] && !i_power_fault) |=> !pfd)
        else $error("fault flag not cleared");

    a_pdc_clear: assert property (@(posedge i_clk) disable iff (i_srst)
        (wr_hit && i_wdata[STS_PDC] && !(pres_prev_valid && (pres_q != pres_now))) |=> !pdc)
        else $error("presence flag not cleared");

    a_cc_clear: assert property (@(posedge i_clk) disable iff (i_srst)
        (wr_hit && i_wdata[STS_CC] && !cc_done) |=> !cc)
        else $error("completion flag not cleared");

    a_dll_clear: assert property (@(posedge i_clk) disable iff (i_srst)
        (wr_hit && i_wdata[STS_DLL_CHG] && (link_q == link_now)) |=> !dll_chg)
        else $error("link flag not cleared");

    // Event setting and holding
    a_pdc_set: assert property (@(posedge i_clk) disable iff (i_srst)
        (pres_prev_valid && (pres_q != pres_now)) |=> pdc)
        else $error("presence change not latched");

    a_dll_set: assert property (@(posedge i_clk) disable iff (i_srst)
        (link_q != link_now) |=> dll_chg)
        else $error("link change not latched");

    a_latch_set: assert property (@(posedge i_clk) disable iff (i_srst)
        (latch_q != i_latch_open) |=> latch_chg)
        else $error("latch change not latched");

    a_latch_sticky: assert property (@(posedge i_clk) disable iff (i_srst)
        latch_chg |=> latch_chg)
        else $error("latch change flag lost");

    a_abp_hold: assert property (@(posedge i_clk) disable iff (i_srst)
        (!i_button_press && !(wr_hit && i_wdata[STS_ABP])) |=> $stable(abp))
        else $error("button flag moved by itself");

    a_pfd_hold: assert property (@(posedge i_clk) disable iff (i_srst)
        (!i_power_fault && !(wr_hit && i_wdata[STS_PFD])) |=> $stable(pfd))
        else $error("fault flag moved by itself");

    a_zero_keep_pfd: assert property (@(posedge i_clk) disable iff (i_srst)
        (wr_hit && !i_wdata[STS_PFD] && pfd) |=> pfd)
        else $error("fault flag lost on zero write");

    a_zero_keep_cc: assert property (@(posedge i_clk) disable iff (i_srst)
        (wr_hit && !i_wdata[STS_CC] && cc) |=> cc)
        else $error("completion flag lost on zero write");

    // Sensor state tracking
    a_latch_state: assert property (@(posedge i_clk) disable iff (i_srst)
        1'b1 |=> latch_q == $past(i_latch_open))
        else $error("latch state not tracked");

    a_pres_state: assert property (@(posedge i_clk) disable iff (i_srst)
        i_slot_impl |=> pres_q == $past(i_card_present))
        else $error("presence state not tracked");

    a_pres_noslot: assert property (@(posedge i_clk) disable iff (i_srst)
        !i_slot_impl |=> pres_q)
        else $error("slotless port not showing presence");

    // Register access
    a_ctl_resv: assert property (@(posedge i_clk) disable iff (i_srst)
        (ctl & ~CTL_WMASK) == 16'h0000)
        else $error("reserved control bit set");

    a_ctl_write: assert property (@(posedge i_clk) disable iff (i_srst)
        wr_hit |=> (ctl & CTL_WMASK) == ($past(i_wdata[15:0]) & CTL_WMASK))
        else $error("control write not stored");

    a_wr_unmapped: assert property (@(posedge i_clk) disable iff (i_srst)
        (i_wr && !hit) |=> $stable(ctl))
        else $error("unmapped write changed control");

    a_rd_unmapped: assert property (@(posedge i_clk) disable iff (i_srst)
        !(i_rd && hit) |=> o_rdata == 32'h0000_0000)
        else $error("read data without mapped read");

    a_rd_resv: assert property (@(posedge i_clk) disable iff (i_srst)
        (i_rd && hit) |=> (o_rdata[31:25] == 7'h00) && !o_rdata[23])
        else $error("reserved status bit set");

    // Read fields of the status half
    a_abp_rd: assert property (@(posedge i_clk) disable iff (i_srst)
        (i_rd && hit) |=> o_rdata[STS_ABP] == $past(abp))
        else $error("button flag misread");

    a_pfd_rd: assert property (@(posedge i_clk) disable iff (i_srst)
        (i_rd && hit) |=> o_rdata[STS_PFD] == $past(pfd))
        else $error("fault flag misread");

    a_latchchg_rd: assert property (@(posedge i_clk) disable iff (i_srst)
        (i_rd && hit) |=> o_rdata[STS_LATCH_CHG] == $past(latch_chg))
        else $error("latch change flag misread");

    a_pdc_rd: assert property (@(posedge i_clk) disable iff (i_srst)
        (i_rd && hit) |=> o_rdata[STS_PDC] == $past(pdc))
        else $error("presence flag misread");

    a_cc_rd: assert property (@(posedge i_clk) disable iff (i_srst)
        (i_rd && hit) |=> o_rdata[STS_CC] == $past(cc))
        else $error("completion flag misread");

    a_latch_rd: assert property (@(posedge i_clk) disable iff (i_srst)
        (i_rd && hit) |=> o_rdata[STS_LATCH_ST] == $past(latch_q))
        else $error("latch state misread");

    a_pres_rd: assert property (@(posedge i_clk) disable iff (i_srst)
        (i_rd && hit) |=> o_rdata[STS_PRES_ST] == $past(pres_q))
        else $error("presence state misread");

    a_dll_rd: assert property (@(posedge i_clk) disable iff (i_srst)
        (i_rd && hit) |=> o_rdata[STS_DLL_CHG] == $past(dll_chg))
        else $error("link flag misread");

    // Interrupt request
    a_fault_irq: assert property (@(posedge i_clk) disable iff (i_srst)
        (pfd && ctl[CTL_PFD_EN] && ctl[CTL_HP_EN]) |=> o_hp_irq)
        else $error("enabled fault event gave no interrupt");

    a_pres_irq: assert property (@(posedge i_clk) disable iff (i_srst)
        (pdc && ctl[CTL_PDC_EN] && ctl[CTL_HP_EN]) |=> o_hp_irq)
        else $error("enabled presence event gave no interrupt");

    a_cc_irq: assert property (@(posedge i_clk) disable iff (i_srst)
        (cc && ctl[CTL_CC_EN] && ctl[CTL_HP_EN]) |=> o_hp_irq)
        else $error("enabled completion gave no interrupt");

    a_dll_irq: assert property (@(posedge i_clk) disable iff (i_srst)
        (dll_chg && ctl[CTL_DLL_EN] && i_dll_supported && ctl[CTL_HP_EN]) |=> o_hp_irq)
        else $error("enabled link event gave no interrupt");

    a_irq_cause: assert property (@(posedge i_clk) disable iff (i_srst)
        o_hp_irq |-> $past(ctl[CTL_HP_EN]))
        else $error("interrupt without master enable");

    a_irq_no_src: assert property (@(posedge i_clk) disable iff (i_srst)
        !(abp || pfd || pdc || cc || dll_chg) |=> !o_hp_irq)
        else $error("interrupt without any flag");

    // Indicators, messages and power control
    a_msg_pair: assert property (@(posedge i_clk) disable iff (i_srst)
        o_attn_msg == o_pwr_msg)
        else $error("indicator messages out of step");

    a_msg_idle: assert property (@(posedge i_clk) disable iff (i_srst)
        !wr_hit |=> !o_attn_msg)
        else $error("message without write");

    a_pwr_ind_follow: assert property (@(posedge i_clk) disable iff (i_srst)
        wr_hit |-> ##2 o_pwr_ind == $past(i_wdata[CTL_PWRI_LO +: 2], 2))
        else $error("power indicator not applied");

    a_pwr_ind_stable: assert property (@(posedge i_clk) disable iff (i_srst)
        (!wr_hit ##1 !wr_hit) |=> $stable(o_pwr_ind))
        else $error("power indicator moved without write");

    a_off_stable: assert property (@(posedge i_clk) disable iff (i_srst)
        (!wr_hit ##1 !wr_hit) |=> $stable(o_slot_power_off))
        else $error("power control moved without write");

    a_ctl_stable: assert property (@(posedge i_clk) disable iff (i_srst)
        !wr_hit |=> $stable(ctl))
        else $error("control moved without write");

    // Command completion timer
    a_cc_timing: assert property (@(posedge i_clk) disable iff (i_srst)
        (ctl_cmd ##1 !ctl_cmd) |-> ##1 cc_done)
        else $error("command completion late");

    a_cc_once: assert property (@(posedge i_clk) disable iff (i_srst)
        cc_done |=> !cc_done)
        else $error("command completion repeated");

    a_cnt_bound: assert property (@(posedge i_clk) disable iff (i_srst)
        cmd_cnt <= 2'(CMD_CYCLES))
        else $error("command timer out of range");
endmodule

// file: sim/hpsc_slot_hw.sv
// Behavioural slot hardware: button, fault sensor, latch, presence, link
`timescale 1ns/1ps
module hpsc_slot_hw (
    // Clock
    input  wire logic i_clk,
    // Sensor outputs towards the port
    output logic      o_button,
    output logic      o_fault,
    output logic      o_latch_open,
    output logic      o_present,
    output logic      o_link
);
    // Idle slot: latch closed, card in, link down
    initial begin
        o_button     = 1'b0;
        o_fault      = 1'b0;
        o_latch_open = 1'b0;
        o_present    = 1'b1;
        o_link       = 1'b0;
    end
    // One-cycle press (sel 0) or fault (sel 1) pulse
    task automatic pulse(input int sel);
        @(posedge i_clk);
        o_button <= (sel == 0);
        o_fault  <= (sel == 1);
        @(posedge i_clk);
        o_button <= 1'b0;
        o_fault  <= 1'b0;
    endtask
    // Level change of latch, presence and link
    task automatic levels(input logic l, input logic p, input logic k);
        @(posedge i_clk);
        o_latch_open <= l;
        o_present    <= p;
        o_link       <= k;
    endtask
endmodule

// file: sim/hpsc_slot_bench.sv
// Register-level bench for the slot hot-plug block
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin error_cnt++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module hpsc_slot_bench;
    import hpsc_pkg::*;
    logic        i_clk, i_srst, i_wr, i_rd, i_slot_impl, o_attn_msg, o_pwr_msg;
    logic        o_slot_power_off, o_hp_irq, btn, flt, lat, pres, lnk;
    logic [7:0]  i_addr;
    logic [31:0] i_wdata, o_rdata, rd_q;
    logic [1:0]  o_attn_ind, o_pwr_ind;
    int          error_cnt = 0, comparisons = 0, cycles = 0;
    hpsc_slot hpsc_slot_i (.i_clk(i_clk), .i_srst(i_srst), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_slot_impl(i_slot_impl), .i_dll_supported(1'b1), .i_button_press(btn),
        .i_power_fault(flt), .i_latch_open(lat), .i_card_present(pres),
        .i_link_active(lnk), .o_attn_ind(o_attn_ind), .o_pwr_ind(o_pwr_ind),
        .o_attn_msg(o_attn_msg), .o_pwr_msg(o_pwr_msg),
        .o_slot_power_off(o_slot_power_off), .o_hp_irq(o_hp_irq));
    hpsc_slot_hw hpsc_slot_hw_i (.i_clk(i_clk), .o_button(btn), .o_fault(flt),
        .o_latch_open(lat), .o_present(pres), .o_link(lnk));
    ////////////////////////////////////////////////////////////////////////////
    // Clock and cycle limit
    initial begin
        i_clk = 1'b0;
        forever #25 i_clk = ~i_clk;
    end
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 2000) begin
            error_cnt++;
            finish_test();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // Bus tasks and verdict
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_addr  <= a;
        i_wdata <= d;
        i_wr    <= 1'b1;
        @(posedge i_clk);
        i_wr    <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge i_clk);
        i_addr <= a;
        i_rd   <= 1'b1;
        @(posedge i_clk);
        i_rd   <= 1'b0;
        #1 rd_q = o_rdata;
    endtask
    task automatic finish_test();
        $display("errors=%0d comparisons=%0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Test sequence
    initial begin
        i_srst = 1'b1;
        i_wr = 1'b0;
        i_rd = 1'b0;
        i_addr = 8'h00;
        i_wdata = 32'h0;
        i_slot_impl = 1'b1;
        repeat (10) @(posedge i_clk);
        i_srst <= 1'b0;
        rd(SLOT_WORD_OFS);
        `CHK(rd_q, 32'h0040_03C0)
        `CHK({o_attn_ind, o_pwr_ind, o_slot_power_off, o_hp_irq}, 6'h3C)
        wr(SLOT_WORD_OFS, 32'h0000_FE7F);
        #1 `CHK({o_attn_msg, o_pwr_msg}, 2'h3)
        @(posedge i_clk);
        #1 `CHK({o_attn_ind, o_pwr_ind, o_slot_power_off}, 5'h0D)
        rd(SLOT_WORD_OFS);
        `CHK(rd_q, 32'h0050_167B)
        `CHK(o_hp_irq, 1'b1)
        wr(SLOT_WORD_OFS, 32'h0000_165B);
        rd(SLOT_WORD_OFS);
        `CHK(rd_q, 32'h0050_165B)
        `CHK(o_hp_irq, 1'b0)
        hpsc_slot_hw_i.pulse(0);
        hpsc_slot_hw_i.pulse(1);
        hpsc_slot_hw_i.levels(1'b1, 1'b0, 1'b1);
        wr(SLOT_WORD_OFS, 32'h0010_165B);
        rd(SLOT_WORD_OFS);
        `CHK(rd_q, 32'h012F_165B)
        `CHK(o_hp_irq, 1'b0)
        wr(SLOT_WORD_OFS, 32'h0000_167B);
        rd(SLOT_WORD_OFS);
        `CHK(o_hp_irq, 1'b1)
        wr(SLOT_WORD_OFS, 32'h011B_167B);
        rd(SLOT_WORD_OFS);
        `CHK(rd_q, 32'h0024_167B)
        `CHK(o_hp_irq, 1'b0)
        wr(8'hF4, 32'h0000_0000);
        rd(8'hF4);
        `CHK(rd_q, 32'h0)
        @(posedge i_clk);
        i_slot_impl <= 1'b0;
        rd(SLOT_WORD_OFS);
        `CHK({rd_q[22], rd_q[15:0]}, 17'h1167B)
        finish_test();
    end
endmodule
